/* File: design/aic_irq_ctrl.sv */
// Interrupt controller of the acquisition converter: flags, enables, limit status and pin.
// Assumes all bus pins and event inputs are synchronous to REF_CLK_I;
// the data bus is split into input, output and an active-low output enable.
`timescale 1ns/10ps
module aic_irq_ctrl #(
    parameter int SETTLE_CYC = aic_pkg::AIC_SETTLE_CYCLES
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic CS_N_I,
    input wire logic RD_N_I,
    input wire logic WR_N_I,
    input wire logic [3:0] WORD_ADDR_LINES_I,
    input wire logic BYTE_SEL_I,
    input wire logic BUS_WIDTH_SELECT_I,
    input wire logic [15:0] DATA_I,
    output logic [15:0] DATA_O,
    output logic DATA_OE_N_O,
    input wire aic_pkg::aic_seq_type SEQ_I,
    input wire aic_pkg::aic_wd_type WD_I,
    input wire logic [4:0] FIFO_COUNT_I,
    input wire logic SHORT_AZ_DONE_I,
    input wire logic FULL_CAL_DONE_I,
    input wire logic STANDBY_I,
    input wire logic DEV_RESET_I,
    output logic INT_N_O
);
    import aic_pkg::*;

    aic_state_type s;       // Registered state
    aic_state_type next_s;  // Next state
    logic wd_hit;           // Watchdog comparison crossed its limit
    logic settle_done;      // Settling delay has elapsed
    logic settle_start;     // Standby bit just cleared
    logic rd_act;           // Read strobe active
    logic wr_act;           // Write strobe active
    logic rd_edge;          // First cycle of a read
    logic wr_edge;          // First cycle of a write
    logic [1:0] lanes;      // Byte lanes touched by the access
    logic [15:0] word;      // Selected register before lane select
    logic [15:0] status_word;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [15:0] lim_set;
    logic [15:0] lim_clr;
    logic fifo_now;         // FIFO count sits at the threshold
    logic [2:0] match_val;
    logic [4:0] fifo_thr;

    // Byte lanes of an access: both in 16-bit mode, one chosen by A0 in 8-bit mode
    function automatic logic [1:0] lane_mask(input logic bw, input logic a0);
        if (!bw) begin
            lane_mask = 2'h3;
        end else begin
            lane_mask = a0 ? 2'h2 : 2'h1;
        end
    endfunction

    // Watchdog limit comparison
    aic_limit_cmp u_cmp (
        .sample_i(WD_I.sample),
        .limit_i(WD_I.limit),
        .above_i(WD_I.above),
        .hit_o(wd_hit)
    );

    // Standby exit settling delay
    aic_settle_timer #(
        .CYCLES(SETTLE_CYC)
    ) u_settle (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .start_i(settle_start),
        .abort_i(STANDBY_I),
        .done_o(settle_done)
    );

    // Falling edge of the standby bit starts the delay
    assign settle_start = s.standby && !STANDBY_I;

    // Access decode and field extraction
    always_comb begin
        rd_act = !CS_N_I && !RD_N_I;
        wr_act = !CS_N_I && !WR_N_I;
        // One access per strobe, however long the host holds it
        rd_edge = rd_act && !s.rd_seen;
        wr_edge = wr_act && !s.wr_seen;
        lanes = lane_mask(BUS_WIDTH_SELECT_I, BYTE_SEL_I);
        match_val = s.enable[AIC_MATCH_LSB +: 3];
        fifo_thr = s.enable[AIC_FIFO_LSB +: 5];
        // Live address and count in the upper status bits
        status_word = {FIFO_COUNT_I, SEQ_I.addr, s.flags};
        // A zero threshold never matches
        fifo_now = (fifo_thr != 5'h00) && (FIFO_COUNT_I == fifo_thr);
    end

    // Event sources set their flags whatever the enables say
    always_comb begin
        flag_set = 8'h00;
        flag_set[AIC_SRC_WD] = WD_I.valid && wd_hit;
        // Instruction zero on the first fetch after start is skipped
        flag_set[AIC_SRC_MATCH] = SEQ_I.fetch && (SEQ_I.addr == match_val)
            && !((SEQ_I.addr == 3'h0) && s.first_zero);
        // Flag on arrival at the threshold, not every cycle it stays there
        flag_set[AIC_SRC_FIFO] = fifo_now && !s.fifo_hit;
        flag_set[AIC_SRC_SHORT_AZ] = SHORT_AZ_DONE_I;
        flag_set[AIC_SRC_FULL_CAL] = FULL_CAL_DONE_I;
        flag_set[AIC_SRC_PAUSE] = SEQ_I.fetch && SEQ_I.pause;
        // Bit 6 has no source and reads zero
        flag_set[AIC_SRC_SPARE] = 1'b0;
        flag_set[AIC_SRC_STANDBY] = settle_done;
        // Limit one in bits 0-7, limit two in 8-15, indexed by instruction
        lim_set = 16'h0000;
        if (WD_I.valid && wd_hit) begin
            lim_set[{WD_I.second, WD_I.instr}] = 1'b1;
        end
    end

    // Register file, clear logic and pin
    always_comb begin
        next_s = s;
        next_s.rd_seen = rd_act;
        next_s.wr_seen = wr_act;
        next_s.standby = STANDBY_I;
        next_s.fifo_hit = fifo_now;
        next_s.oe_n = !rd_act;
        flag_clr = 8'h00;
        lim_clr = 16'h0000;
        word = 16'h0000;
        // Register selection; unmapped words read zero
        unique case (WORD_ADDR_LINES_I)
            AIC_ENABLE_OFS: begin
                word = s.enable;
            end
            AIC_STATUS_OFS: begin
                word = status_word;
                // The flags live in the low byte, so that lane clears them
                if (rd_edge && lanes[0]) begin
                    flag_clr = 8'hFF;
                end
            end
            AIC_LIMIT_OFS: begin
                word = s.limit_stat;
                if (rd_edge) begin
                    lim_clr = {{8{lanes[1]}}, {8{lanes[0]}}};
                end
            end
            default: begin
                word = 16'h0000;
            end
        endcase
        // Capture read data at the first edge of the strobe
        if (rd_edge) begin
            if (!BUS_WIDTH_SELECT_I) begin
                next_s.rdata = word;
            end else if (BYTE_SEL_I) begin
                next_s.rdata = {8'h00, word[15:8]};
            end else begin
                next_s.rdata = {8'h00, word[7:0]};
            end
        end
        // Enable writes; 8-bit mode carries either byte on the low lines
        if (wr_edge && (WORD_ADDR_LINES_I == AIC_ENABLE_OFS)) begin
            if (lanes[0]) begin
                next_s.enable[7:0] = DATA_I[7:0];
            end
            if (lanes[1]) begin
                next_s.enable[15:8] = BUS_WIDTH_SELECT_I ? DATA_I[7:0] : DATA_I[15:8];
            end
        end
        // Device reset command clears every flag
        if (DEV_RESET_I) begin
            flag_clr = 8'hFF;
            lim_clr = 16'hFFFF;
        end
        // Set wins over a clear in the same cycle, so no event is lost
        next_s.flags = (s.flags & ~flag_clr) | flag_set;
        next_s.limit_stat = (s.limit_stat & ~lim_clr) | lim_set;
        // Armed by start, disarmed by the first fetch of instruction zero
        if (SEQ_I.start) begin
            next_s.first_zero = 1'b1;
        end else if (SEQ_I.fetch && (SEQ_I.addr == 3'h0)) begin
            next_s.first_zero = 1'b0;
        end
        // Pin follows the new flags and enables with no extra lag; the
        // sequencer is never stalled from here, it only sees its own fetches
        next_s.int_n = ~|(next_s.flags & next_s.enable[7:0]);
    end

    // State register; the enable word resets to zero
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            s <= AIC_STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign DATA_O = s.rdata;
    assign DATA_OE_N_O = s.oe_n;
    assign INT_N_O = s.int_n;

    default clocking dc @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    pin_follows_a: assert property (INT_N_O == ~|(s.flags & s.enable[7:0]))
        else $error("interrupt pin disagrees with flags and enables");
    flag_sticky_a: assert property (SHORT_AZ_DONE_I |=> s.flags[AIC_SRC_SHORT_AZ])
        else $error("short auto-zero flag not set");
    spare_zero_a: assert property (s.flags[6] == 1'b0)
        else $error("spare flag bit set");
    wd_fire_a: assert property (WD_I.valid && wd_hit |=> s.flags[0])
        else $error("watchdog flag missed");
    limit_rec_a: assert property (WD_I.valid && wd_hit && WD_I.second |=> |s.limit_stat[15:8])
        else $error("limit two crossing not recorded");
    match_hit_a: assert property (SEQ_I.fetch && SEQ_I.addr == match_val && SEQ_I.addr != 3'h0
        |=> s.flags[1])
        else $error("address match flag missed");
    first_skip_a: assert property (SEQ_I.start ##1 (SEQ_I.fetch && SEQ_I.addr == 3'h0 && !DEV_RESET_I
        && !rd_edge && match_val == 3'h0 && !s.flags[1]) |=> !s.flags[1])
        else $error("match flagged on first fetch of zero");
    fifo_thr_a: assert property (fifo_now && !s.fifo_hit |=> s.flags[2] && fifo_thr != 5'h00)
        else $error("fifo level flag missed");
    pause_a: assert property (SEQ_I.fetch && SEQ_I.pause |=> s.flags[5])
        else $error("pause flag missed");
    stby_a: assert property (settle_done |=> s.flags[7])
        else $error("standby exit flag missed");
    enable_wr_a: assert property (wr_edge && WORD_ADDR_LINES_I == AIC_ENABLE_OFS && !BUS_WIDTH_SELECT_I
        |=> s.enable == $past(DATA_I))
        else $error("enable write not stored");
    reset_clr_a: assert property (DEV_RESET_I && flag_set == 8'h00 |=> s.flags == 8'h00)
        else $error("device reset left flags set");

    cov_int: cover property ($fell(INT_N_O));
    cov_status_rd: cover property (rd_edge && WORD_ADDR_LINES_I == AIC_STATUS_OFS && s.flags != 8'h00);
    cov_byte_wr: cover property (wr_edge && BUS_WIDTH_SELECT_I && BYTE_SEL_I);
    cov_settle: cover property (settle_done);
endmodule

/* File: include/aic_pkg.sv */
// Constants, carrier structs and state types for the acquisition interrupt controller.
// Assumes a single 50 MHz device clock and a synchronous, active-low reset.
package aic_pkg;

    // Word offsets on the four word address lines
    localparam logic [3:0] AIC_ENABLE_OFS = 4'h9;
    localparam logic [3:0] AIC_STATUS_OFS = 4'hA;
    localparam logic [3:0] AIC_LIMIT_OFS = 4'hD;

    // Field positions inside the enable and status words
    localparam int AIC_MATCH_LSB = 8;
    localparam int AIC_FIFO_LSB = 11;

    // Source positions in the flag byte
    localparam int AIC_SRC_WD = 0;
    localparam int AIC_SRC_MATCH = 1;
    localparam int AIC_SRC_FIFO = 2;
    localparam int AIC_SRC_SHORT_AZ = 3;
    localparam int AIC_SRC_FULL_CAL = 4;
    localparam int AIC_SRC_PAUSE = 5;
    localparam int AIC_SRC_SPARE = 6;
    localparam int AIC_SRC_STANDBY = 7;

    // Settling delay after standby exit
    localparam int AIC_CLK_HZ = 50000000;
    localparam int AIC_SETTLE_TIME_MS = 10;
    localparam int AIC_SETTLE_CYCLES = AIC_SETTLE_TIME_MS * (AIC_CLK_HZ / 1000);
    localparam int AIC_TIMER_W = 20;

    // Sequencer events seen by the controller
    typedef struct packed {
        logic start;       // Start bit written to one
        logic fetch;       // Instruction fetched this cycle
        logic pause;       // Pause bit of the fetched instruction
        logic [2:0] addr;  // Current instruction address
    } aic_seq_type;

    // One watchdog comparison
    typedef struct packed {
        logic valid;         // Comparison result is valid this cycle
        logic second;        // Zero for limit one, one for limit two
        logic [2:0] instr;   // Instruction doing the comparison
        logic [8:0] sample;  // Signed sampled input
        logic [8:0] limit;   // Signed limit value
        logic above;         // One: fire above limit, zero: below
    } aic_wd_type;

    // Whole state of the top module
    typedef struct packed {
        logic [15:0] enable;
        logic [7:0] flags;
        logic [15:0] limit_stat;
        logic first_zero;
        logic fifo_hit;
        logic standby;
        logic rd_seen;
        logic wr_seen;
        logic [15:0] rdata;
        logic oe_n;
        logic int_n;
    } aic_state_type;

    localparam aic_state_type AIC_STATE_RST = '{enable: 16'h0000, flags: 8'h00, limit_stat: 16'h0000,
        first_zero: 1'b0, fifo_hit: 1'b0, standby: 1'b0, rd_seen: 1'b0, wr_seen: 1'b0,
        rdata: 16'h0000, oe_n: 1'b1, int_n: 1'b1};

    // Whole state of the settling timer
    typedef struct packed {
        logic busy;
        logic [AIC_TIMER_W-1:0] count;
        logic done;
    } aic_timer_type;

    localparam aic_timer_type AIC_TIMER_RST = '{busy: 1'b0, count: 20'h00000, done: 1'b0};

endpackage

/* File: design/aic_limit_cmp.sv */
// Signed limit comparator for one watchdog comparison.
// Assumes sample and limit are nine-bit two's complement values.
`timescale 1ns/10ps
module aic_limit_cmp (
    input wire logic [8:0] sample_i,
    input wire logic [8:0] limit_i,
    input wire logic above_i,
    output logic hit_o
);
    // Direction bit picks which side of the limit counts as a crossing
    always_comb begin
        if (above_i) begin
            hit_o = $signed(sample_i) > $signed(limit_i);
        end else begin
            hit_o = $signed(sample_i) < $signed(limit_i);
        end
    end
endmodule

/* File: design/aic_settle_timer.sv */
// Down counter that times the analog settling delay after standby exit.
// Assumes start is a one-cycle pulse; abort holds the timer idle.
`timescale 1ns/10ps
module aic_settle_timer #(
    parameter int CYCLES = aic_pkg::AIC_SETTLE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic done_o
);
    import aic_pkg::*;

    aic_timer_type s;       // Registered state
    aic_timer_type next_s;  // Next state

    // Done pulses exactly CYCLES edges after the start pulse
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (abort_i) begin
            // Going back to standby cancels a pending completion
            next_s.busy = 1'b0;
        end else if (start_i) begin
            next_s.busy = 1'b1;
            next_s.count = AIC_TIMER_W'(CYCLES - 1);
        end else if (s.busy) begin
            if (s.count == '0) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end else begin
                next_s.count = s.count - 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s <= AIC_TIMER_RST;
        end else begin
            s <= next_s;
        end
    end

    assign done_o = s.done;
endmodule

/* File: tb/aic_host_model.sv */
// Host processor model: performs register cycles on the parallel bus.
// Assumes the bench calls its tasks; strobes change just after a clock rise.
`timescale 1ns/10ps
module aic_host_model (
    input wire logic clk_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [3:0] addr_o,
    output logic bsel_o,
    output logic bw_o,
    output logic [15:0] data_o
);
    // Idle bus: nothing selected, 16-bit width
    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 4'h0;
        bsel_o = 1'b0;
        bw_o = 1'b0;
        data_o = 16'h0000;
    end

    // Bus width and byte lane for the following cycles
    task automatic mode(input logic bw, input logic bs);
        @(posedge clk_i);
        #1;
        bw_o = bw;
        bsel_o = bs;
    endtask

    // One read or write; strobe held over the answer edge, then one idle edge
    task automatic access(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        #1;
        cs_n_o = 1'b0;
        addr_o = a;
        if (wr) begin
            wr_n_o = 1'b0;
            data_o = d;
        end else begin
            rd_n_o = 1'b0;
        end
        repeat (2) @(posedge clk_i);
        #1;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        // Released lines flip so a stale value is never mistaken for data
        data_o = ~data_o;
        addr_o = ~a;
        // Return just after the idle edge so the caller never races a clock rise
        @(posedge clk_i);
        #1;
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the interrupt controller.
// Assumes the host model drives the bus and this module drives the event inputs.
`timescale 1ns/10ps
module tb_top;
    import aic_pkg::*;
    localparam int SETTLE = 20; // Shortened settling delay
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, rd_n, wr_n, bsel, bw, oe_n, int_n;
    logic [3:0] addr;
    logic [15:0] din, dout, v;
    aic_seq_type seq;
    aic_wd_type wd;
    logic [4:0] fifo;
    logic saz, fcal, stby, dres;
    integer bad_count = 0;
    integer tests_run = 0;
    integer seed = 64;
    logic [15:0] exp_q[$]; // Expected read data, oldest first
    logic [15:0] en = 16'h0000; // Enable value the bench wrote last
    logic [7:0] flg = 8'h00; // Flags the bench expects to be set

    // Free running 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    aic_host_model aic_host_model_inst (.clk_i(ref_clk), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .addr_o(addr), .bsel_o(bsel), .bw_o(bw), .data_o(din));
    aic_irq_ctrl #(.SETTLE_CYC(SETTLE)) aic_irq_ctrl_inst (.REF_CLK_I(ref_clk), .RST_N_I(rst_n),
        .CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n), .WORD_ADDR_LINES_I(addr), .BYTE_SEL_I(bsel),
        .BUS_WIDTH_SELECT_I(bw), .DATA_I(din), .DATA_O(dout), .DATA_OE_N_O(oe_n), .SEQ_I(seq), .WD_I(wd),
        .FIFO_COUNT_I(fifo), .SHORT_AZ_DONE_I(saz), .FULL_CAL_DONE_I(fcal), .STANDBY_I(stby),
        .DEV_RESET_I(dres), .INT_N_O(int_n));

    task automatic fail(input string m);
        bad_count++;
        $display("FAIL at %0t: %s", $time, m);
    endtask

    // Compare one read word
    task automatic chk_data(input logic [15:0] got, input logic [15:0] e);
        tests_run++;
        if (got !== e) fail($sformatf("read %h expected %h", got, e));
    endtask

    // Pin must be low exactly when an expected flag meets its enable
    task automatic chk_pin();
        logic e;
        e = ~|(flg & en[7:0]);
        tests_run++;
        if (int_n !== e) fail("interrupt pin wrong");
    endtask

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic tdone(input string n);
        $display("test %s done", n);
    endtask

    // Note the expected word, then run the read cycle
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        aic_host_model_inst.access(1'b0, a, 16'h0000);
    endtask

    // Status read: upper fields are live, flags clear afterwards
    task automatic rd_stat();
        rd(AIC_STATUS_OFS, {fifo, seq.addr, flg});
        flg = 8'h00;
        chk_pin();
    endtask

    // Enable write, always followed by a status read to drop stale flags
    task automatic wr_en(input logic [15:0] val);
        aic_host_model_inst.access(1'b1, AIC_ENABLE_OFS, val);
        en = val;
        chk_pin();
        rd_stat();
    endtask

    // One-cycle event; 6 is a watchdog miss, 7 a below-limit hit
    task automatic ev(input int s, input logic [2:0] a);
        tick();
        case (s)
            0: wd = '{valid: 1'b1, second: a[0], instr: a, sample: 9'h005, limit: 9'h1FE, above: 1'b1};
            6: wd = '{valid: 1'b1, second: a[0], instr: a, sample: 9'h1F0, limit: 9'h000, above: 1'b1};
            7: wd = '{valid: 1'b1, second: a[0], instr: a, sample: 9'h1F0, limit: 9'h000, above: 1'b0};
            3: saz = 1'b1;
            4: fcal = 1'b1;
            default: seq = '{start: 1'b0, fetch: 1'b1, pause: (s == 5), addr: a};
        endcase
        tick();
        wd.valid = 1'b0;
        seq.fetch = 1'b0;
        seq.pause = 1'b0;
        saz = 1'b0;
        fcal = 1'b0;
        repeat (2) tick();
    endtask

    // Closing: leftover notes mean a read answer never came
    task automatic summarize();
        if (exp_q.size() != 0) fail("read answers missing");
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Result watcher: each fall of the output enable carries one read word
    always @(negedge oe_n) begin
        #1;
        if (exp_q.size() == 0) fail("unexpected read data");
        else chk_data(dout, exp_q.pop_front());
    end

    // Hang guard, far beyond the planned run of about four hundred cycles
    initial begin
        #200us;
        fail("timeout");
        summarize();
    end

    // Main sequence
    initial begin
        seq = '0;
        wd = '0;
        fifo = 5'h00;
        saz = 1'b0;
        fcal = 1'b0;
        stby = 1'b0;
        dres = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        rd(AIC_ENABLE_OFS, 16'h0000);
        rd_stat();
        tdone("reset");
        // Random enable value, read back whole and per byte lane
        v = 16'($random(seed));
        wr_en(v);
        rd(AIC_ENABLE_OFS, v);
        aic_host_model_inst.access(1'b1, AIC_STATUS_OFS, 16'hFFFF);
        rd(4'h3, 16'h0000);
        rd(AIC_ENABLE_OFS, v);
        aic_host_model_inst.mode(1'b1, 1'b1);
        rd(AIC_ENABLE_OFS, {8'h00, v[15:8]});
        aic_host_model_inst.mode(1'b1, 1'b0);
        rd(AIC_ENABLE_OFS, {8'h00, v[7:0]});
        aic_host_model_inst.mode(1'b0, 1'b0);
        tdone("enable register");
        // Sources 0 to 5 masked, then enabled; match value 3, threshold 7
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 6; s++) begin
                wr_en(16'h3B00 | (p ? (16'h0001 << s) : 16'h0000));
                if (s == 2) begin
                    tick();
                    fifo = 5'd7;
                    repeat (3) tick();
                end else begin
                    // Pause fetch sits off the match address so only its own flag rises
                    ev(s, (s == 5) ? 3'd5 : 3'd3);
                end
                flg[s] = 1'b1;
                chk_pin();
                if (s == 0) rd(AIC_LIMIT_OFS, 16'h0800);
                rd_stat();
                fifo = 5'd0;
            end
        end
        tdone("sources");
        // Watchdog direction and a fetch at a different address
        wr_en(16'h0303);
        ev(6, 3'd2);
        ev(1, 3'd2);
        chk_pin();
        ev(7, 3'd2);
        flg[0] = 1'b1;
        chk_pin();
        rd(AIC_LIMIT_OFS, 16'h0004);
        rd_stat();
        tdone("watchdog");
        // Match on zero skips only the first fetch after a start
        wr_en(16'h0002);
        // Start is sampled at the next edge, the fetch one edge later
        seq.start = 1'b1;
        ev(1, 3'd0);
        chk_pin();
        ev(1, 3'd0);
        flg[1] = 1'b1;
        chk_pin();
        rd_stat();
        tdone("match zero");
        // Threshold zero never fires, threshold 31 does
        wr_en(16'h0004);
        fifo = 5'd5;
        tick();
        fifo = 5'd0;
        repeat (3) tick();
        chk_pin();
        wr_en(16'hF804);
        fifo = 5'd31;
        repeat (3) tick();
        flg[2] = 1'b1;
        chk_pin();
        rd_stat();
        fifo = 5'd0;
        tdone("fifo level");
        // Standby exit: silent during settling, flagged after
        wr_en(16'h0080);
        stby = 1'b1;
        repeat (5) tick();
        stby = 1'b0;
        repeat (SETTLE / 2) tick();
        chk_pin();
        repeat (SETTLE) tick();
        flg[7] = 1'b1;
        chk_pin();
        rd_stat();
        tdone("standby");
        // Device reset command clears pending flags, keeps enables
        wr_en(16'h0018);
        ev(3, 3'd0);
        ev(4, 3'd0);
        flg = 8'h18;
        chk_pin();
        dres = 1'b1;
        tick();
        dres = 1'b0;
        tick();
        flg = 8'h00;
        chk_pin();
        rd_stat();
        tdone("device reset");
        summarize();
    end
endmodule
